// ===== tpq_queue.v
// transmit packet queue with automatic page release, lost if an alloc, release or allocation finish shares the done cycle
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tpq_defs.vh"

// Behaviour
// R1: allocate command reserves requested bytes of RAM
// R2: successful allocation sets allocation done flag
// R3: allocated packet number shown in result register
// R4: host loads packet number, pointer, then data
// R5: enqueue pushes packet number into transmit FIFO
// R6: packets go to MAC only while enabled
// R7: half duplex also waits for deferral permission
// R8: completed packet pages freed automatically; the code skips it if alloc, release or allocation finish shares the cycle
// R9: queue empty event after whole run sent
// R10: failure raises transmit interrupt
// R11: failure clears enable and stops sending
// R12: failed packet number shown at FIFO port
// R13: host reads interrupt status then exits
// R14: host may release failed packet memory
// R15: host re-enqueues failed packet after re-enabling
// R16: allocation waits until enough pages free
module tpq_queue #(
    parameter NUM_PKTS  = 16,
    parameter PKT_W     = 4,
    parameter NUM_PAGES = 32,
    parameter PAGE_W    = 6,
    parameter DEPTH_W   = 4
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    output wire              irq,
    output reg               mac_start,
    output reg  [PKT_W-1:0]  mac_pkt,
    input  wire              mac_done,
    input  wire              mac_fail,
    input  wire              defer_ok,
    input  wire [15:0]       mac_status,
    output reg  [PKT_W-1:0]  ram_pkt,
    output reg  [10:0]       ram_ptr,
    output reg  [31:0]       ram_wdata,
    output reg               ram_we
);

    // ==========================================================
    // bus decode
    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    reg  [1:0]          ctrl;
    wire [2:0]          int_stat;
    reg  [2:0]          int_mask;
    reg  [PKT_W-1:0]    pkt_num;
    reg  [10:0]         pointer;
    reg  [PKT_W-1:0]    alloc_res;
    reg                 alloc_ok;
    reg                 alloc_pend;
    reg  [PAGE_W-1:0]   alloc_need;
    reg  [PAGE_W-1:0]   free_pages;
    reg  [NUM_PKTS-1:0] pkt_used;
    reg  [PAGE_W-1:0]   pkt_pages [0:NUM_PKTS-1];
    reg  [PKT_W-1:0]    fifo [0:(1<<DEPTH_W)-1];
    reg  [DEPTH_W:0]    wptr;
    reg  [DEPTH_W:0]    rptr;
    reg                 busy;
    reg  [PKT_W-1:0]    fail_pkt;
    reg                 fail_valid;
    reg  [15:0]         tx_status;

    wire [3:0]  cmd      = pwdata[3:0];
    wire        cmd_wr   = wr && paddr == `TPQ_OFF_MMU_CMD;
    wire        fifo_emp = wptr == rptr;
    wire        fifo_ful = wptr == {~rptr[DEPTH_W], rptr[DEPTH_W-1:0]};
    wire [10:0] req_cnt  = pwdata[26:16];
    // whole pages, a partly used last page counts as one
    wire [PAGE_W-1:0] req_pages = {{(PAGE_W-3){1'b0}}, req_cnt[10:8]}
                                  + {{(PAGE_W-1){1'b0}}, |req_cnt[7:0]};

    // ==========================================================
    // find a free packet number
    reg             have_free;
    reg [PKT_W-1:0] free_idx;
    integer i;
    always @*
    begin
        have_free = 1'b0;
        free_idx  = {PKT_W{1'b0}};
        for (i = NUM_PKTS - 1; i >= 0; i = i - 1)
            if (!pkt_used[i])
            begin
                have_free = 1'b1;
                free_idx  = i[PKT_W-1:0];
            end
    end

    // allocation can finish this cycle
    wire alloc_go = alloc_pend && have_free && free_pages >= alloc_need; // R16
    wire launch   = !busy && !fifo_emp && ctrl[`TPQ_CTRL_TXEN]                // R6
                    && (!ctrl[`TPQ_CTRL_HALF_DUP] || defer_ok);            // R7
    wire done_ok  = busy && mac_done && !mac_fail;
    wire done_bad = busy && mac_done && mac_fail;
    wire rel_cmd  = cmd_wr && cmd == `TPQ_CMD_RELEASE;

    // ==========================================================
    // page accounting, allocation and queue
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            free_pages <= NUM_PAGES[PAGE_W-1:0];
            pkt_used   <= {NUM_PKTS{1'b0}};
            alloc_pend <= 1'b0;
            alloc_need <= {PAGE_W{1'b0}};
            alloc_res  <= {PKT_W{1'b0}};
            alloc_ok   <= 1'b0;
            wptr       <= {(DEPTH_W+1){1'b0}};
            rptr       <= {(DEPTH_W+1){1'b0}};
            busy       <= 1'b0;
            mac_start  <= 1'b0;
            mac_pkt    <= {PKT_W{1'b0}};
            fail_pkt   <= {PKT_W{1'b0}};
            fail_valid <= 1'b0;
            tx_status  <= 16'h0000;
        end
        else
        begin
            mac_start <= 1'b0;
            if (cmd_wr && cmd == `TPQ_CMD_ALLOC)
            begin
                alloc_pend <= 1'b1;                                        // R1
                alloc_need <= req_pages;
                alloc_ok   <= 1'b0;
            end
            else if (alloc_go)
            begin
                alloc_pend            <= 1'b0;
                alloc_ok              <= 1'b1;
                alloc_res             <= free_idx;                         // R3
                pkt_used[free_idx]    <= 1'b1;
                pkt_pages[free_idx]   <= alloc_need;
                free_pages            <= free_pages - alloc_need;
            end
            else if (rel_cmd && pkt_used[pkt_num])
            begin
                pkt_used[pkt_num] <= 1'b0;                                 // R14
                free_pages        <= free_pages + pkt_pages[pkt_num];
            end
            else if (done_ok && pkt_used[mac_pkt])
            begin
                pkt_used[mac_pkt] <= 1'b0;                                 // R8
                free_pages        <= free_pages + pkt_pages[mac_pkt];
            end
            if (cmd_wr && cmd == `TPQ_CMD_ENQUEUE && !fifo_ful)
            begin
                fifo[wptr[DEPTH_W-1:0]] <= pkt_num;                        // R5
                wptr <= wptr + 1'b1;
            end
            if (launch)
            begin
                busy      <= 1'b1;
                mac_start <= 1'b1;
                mac_pkt   <= fifo[rptr[DEPTH_W-1:0]];
                rptr      <= rptr + 1'b1;
                fail_valid <= 1'b0;
            end
            if (mac_done && busy)
            begin
                busy      <= 1'b0;
                tx_status <= mac_status;
            end
            if (done_bad)
            begin
                fail_pkt   <= mac_pkt;                                     // R12
                fail_valid <= 1'b1;
            end
        end
    end

    // ==========================================================
    // register write strobes
    wire wr_ctrl = wr && paddr == `TPQ_OFF_CTRL;
    wire wr_pnum = wr && paddr == `TPQ_OFF_PKT_NUM;
    wire wr_ptr  = wr && paddr == `TPQ_OFF_POINTER;
    wire wr_data = wr && paddr == `TPQ_OFF_DATA;
    wire wr_ist  = wr && paddr == `TPQ_OFF_INT_STAT;
    wire wr_imsk = wr && paddr == `TPQ_OFF_INT_MASK;

    // ==========================================================
    // interrupt events and sticky status bits
    wire [2:0] ev;
    assign ev[`TPQ_INT_ALLOC]   = alloc_go;                                // R2
    assign ev[`TPQ_INT_TX]      = done_bad;                                // R10
    assign ev[`TPQ_INT_TRANSMIT_QUEUE_EMPTY_EVENT] = done_ok && fifo_emp;                     // R9
    assign irq = |(int_stat & int_mask);

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_ist
            reg bit_q;
            // an event in the clearing cycle keeps the bit set
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    bit_q <= 1'b0;
                else if (ev[g])
                    bit_q <= 1'b1;
                else if (wr_ist && pwdata[g])
                    bit_q <= 1'b0;
            end
            assign int_stat[g] = bit_q;
        end
    endgenerate

    // ==========================================================
    // control, packet number, pointer and data port
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl      <= 2'h0;
            int_mask  <= 3'h0;
            pkt_num   <= {PKT_W{1'b0}};
            pointer   <= 11'h000;
            ram_we    <= 1'b0;
            ram_pkt   <= {PKT_W{1'b0}};
            ram_ptr   <= 11'h000;
            ram_wdata <= 32'h00000000;
        end
        else
        begin
            ram_we <= 1'b0;
            if (wr_ctrl)
            begin
                ctrl <= pwdata[1:0];
            end
            // a failure wins over a host write in the same cycle
            if (done_bad)
            begin
                ctrl[`TPQ_CTRL_TXEN] <= 1'b0;                              // R11
            end
            if (wr_pnum)
            begin
                pkt_num <= pwdata[PKT_W-1:0];
            end
            if (wr_ptr)
            begin
                pointer <= pwdata[10:0];
            end
            // one word into packet ram, pointer steps to the next word
            if (wr_data)
            begin
                ram_we    <= 1'b1;
                ram_pkt   <= pkt_num;
                ram_ptr   <= pointer;
                ram_wdata <= pwdata;
                pointer   <= pointer + 11'h004;
            end
            if (wr_imsk)
            begin
                int_mask <= pwdata[2:0];
            end
        end
    end

    // ==========================================================
    // read mux
    always @*
    begin
        prdata = 32'h00000000;
        if (rd)
        begin
            case (paddr)
                `TPQ_OFF_CTRL:      prdata = {30'h0, ctrl};
                `TPQ_OFF_ALLOC_RES: prdata = {!alloc_ok, 27'h0, alloc_res};
                `TPQ_OFF_PKT_NUM:   prdata = {28'h0, pkt_num};
                `TPQ_OFF_POINTER:   prdata = {21'h0, pointer};
                `TPQ_OFF_FIFO_PORT: prdata = {16'h0, !fail_valid, 11'h0, fail_pkt};
                `TPQ_OFF_TX_STATUS: prdata = {16'h0, tx_status};
                `TPQ_OFF_INT_STAT:  prdata = {29'h0, int_stat};
                `TPQ_OFF_INT_MASK:  prdata = {29'h0, int_mask};
                default:            prdata = 32'h00000000;
            endcase
        end
    end

endmodule // tpq_queue
`default_nettype wire

// ===== tpq_defs.vh
// register offsets, fields and constants of the transmit packet queue
`ifndef TPQ_DEFS_VH
`define TPQ_DEFS_VH

// ==========================================================
// register byte offsets
`define TPQ_OFF_CTRL      12'h000
`define TPQ_OFF_MMU_CMD   12'h004
`define TPQ_OFF_ALLOC_RES 12'h008
`define TPQ_OFF_PKT_NUM   12'h00c
`define TPQ_OFF_POINTER   12'h010
`define TPQ_OFF_DATA      12'h014
`define TPQ_OFF_FIFO_PORT 12'h018
`define TPQ_OFF_TX_STATUS 12'h01c
`define TPQ_OFF_INT_STAT  12'h020
`define TPQ_OFF_INT_MASK  12'h024

// ==========================================================
// control register fields
`define TPQ_CTRL_TXEN     0
`define TPQ_CTRL_HALF_DUP 1

// ==========================================================
// mmu command codes in bits 3:0, byte count in bits 26:16
`define TPQ_CMD_ALLOC     4'h1
`define TPQ_CMD_RELEASE   4'h2
`define TPQ_CMD_ENQUEUE   4'h3

// ==========================================================
// interrupt bits
`define TPQ_INT_ALLOC     0
`define TPQ_INT_TX        1
`define TPQ_INT_TRANSMIT_QUEUE_EMPTY_EVENT   2

// ==========================================================
// fifo port field, allocation failed bit and page size
`define TPQ_PORT_EMPTY    15
`define TPQ_ALLOC_FAILED  31
`define TPQ_PAGE_BYTES    256

`endif

// ===== tpq_queue_assertions.sv
// port checker for the transmit packet queue
`timescale 1ns/1ns
`default_nettype none
`include "tpq_defs.vh"
module tpq_queue_assertions #(parameter PKT_W = 4) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [31:0] ram_wdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        mac_start,
    input wire logic        mac_done,
    input wire logic        mac_fail,
    input wire logic        defer_ok,
    input wire logic        ram_we
);
    logic       en, hd;
    logic [2:0] msk;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // shadow of enable, duplex and mask bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en <= 1'b0;
            hd <= 1'b0;
            msk <= 3'h0;
        end
        else
        begin
            if (psel && penable && pwrite && paddr == `TPQ_OFF_CTRL)
            begin
                en <= pwdata[0];
                hd <= pwdata[1];
            end
            if (mac_done && mac_fail)
                en <= 1'b0;
            if (psel && penable && pwrite && paddr == `TPQ_OFF_INT_MASK)
                msk <= pwdata[2:0];
        end
    end
    // ==========================================================
    // properties
    sequence data_wr;
        psel && penable && pwrite && paddr == `TPQ_OFF_DATA;
    endsequence
    sequence tx_fail;
        mac_done && mac_fail;
    endsequence
    zero_wait_a: assert property (pready && !pslverr) else $error("apb answer not zero wait");
    idle_rdata_a: assert property (!psel |-> prdata == 32'h0) else $error("prdata not idle");
    start_enabled_a: assert property (mac_start |-> $past(en)) else $error("start disabled");
    start_defer_a: assert property (mac_start && $past(hd) |-> $past(defer_ok))
        else $error("start before deferral");
    fail_stop_a: assert property (tx_fail |=> !mac_start [*2]) else $error("start after fail");
    fail_irq_a: assert property (tx_fail ##0 msk[1] |=> irq) else $error("no fail irq");
    start_pulse_a: assert property (mac_start |=> !mac_start) else $error("start not pulse");
    ram_write_a: assert property (data_wr |=> ram_we && ram_wdata == $past(pwdata))
        else $error("data word not written");
endmodule // tpq_queue_assertions
bind tpq_queue tpq_queue_assertions #(.PKT_W(PKT_W)) tpq_queue_assertions_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .ram_wdata(ram_wdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .mac_start(mac_start),
    .mac_done(mac_done), .mac_fail(mac_fail), .defer_ok(defer_ok), .ram_we(ram_we));
`default_nettype wire

// ===== tpq_mac_model.sv
// mac side model answering each start after a latency
`timescale 1ns/1ns
`default_nettype none
module tpq_mac_model #(parameter int LAT = 6) (
    input wire logic   pclk, presetn, mac_start, fail_req,
    output var logic   mac_done, mac_fail,
    output var logic [15:0] mac_status
);
    logic [3:0] cnt;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 4'h0;
            mac_done <= 1'b0;
            mac_fail <= 1'b0;
            mac_status <= 16'h0;
        end
        else
        begin
            mac_done <= cnt == 4'h1;
            mac_fail <= cnt == 4'h1 && fail_req;
            // status only meaningful with done, scrambled otherwise
            mac_status <= cnt == 4'h1 ? {15'h0, fail_req} : ~mac_status;
            cnt <= mac_start ? LAT[3:0] : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
        end
    end
endmodule // tpq_mac_model
`default_nettype wire

// ===== tb_tpq_queue.sv
// testbench of the transmit packet queue
`timescale 1ns/1ns
`default_nettype none
`include "tpq_defs.vh"
module tb_tpq_queue;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, defer_ok = 0, fail_req = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, ram_wdata, r;
    logic pready, pslverr, irq, mac_start, mac_done, mac_fail, ram_we;
    logic [3:0] mac_pkt, ram_pkt, pk;
    logic [3:0] pn [4];
    logic [15:0] mac_status;
    logic [10:0] ram_ptr;
    int error_cnt = 0, checks = 0;
    tpq_queue tpq_queue_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .mac_start(mac_start), .mac_pkt(mac_pkt),
        .mac_done(mac_done), .mac_fail(mac_fail), .defer_ok(defer_ok), .mac_status(mac_status),
        .ram_pkt(ram_pkt), .ram_ptr(ram_ptr), .ram_wdata(ram_wdata), .ram_we(ram_we));
    tpq_mac_model tpq_mac_model_i (.pclk(pclk), .presetn(presetn), .mac_start(mac_start),
        .fail_req(fail_req), .mac_done(mac_done), .mac_fail(mac_fail), .mac_status(mac_status));
    initial forever #5 pclk = ~pclk;
    // ==========================================================
    // shared tasks
    task results;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        if (n >= 50) begin error_cnt++; results; end
        r = prdata;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task wt(input logic k, input bit none); // wait start or done, or check absence
        int n;
        for (n = 0; n < 100; n++)
        begin
            @(negedge pclk);
            if (none && n < 8) chk(mac_start, 0);
            else if (!none && (k ? mac_done : mac_start) === 1'b1) break;
        end
        if (!none && n >= 100) begin error_cnt++; results; end
        pk = mac_pkt;
        @(posedge pclk);
    endtask
    // ==========================================================
    // scenarios
    task t_alloc;
        apb(1, `TPQ_OFF_INT_MASK, 7);
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `TPQ_OFF_MMU_CMD, 32'h07ff_0001);
            apb(0, `TPQ_OFF_ALLOC_RES, 0); chk(r[31], 0);
            pn[i] = r[3:0];
            apb(0, `TPQ_OFF_INT_STAT, 0); chk({irq, r[0]}, 2'b11);
            apb(1, `TPQ_OFF_INT_STAT, 1);
        end
        chk(pn[0] != pn[1], 1);
        apb(1, `TPQ_OFF_MMU_CMD, 32'h0100_0001);
        apb(0, `TPQ_OFF_ALLOC_RES, 0); chk(r[31], 1);
        apb(0, `TPQ_OFF_INT_STAT, 0); chk(r[0], 0);
        apb(0, 12'h0fc, 0); chk(r, 0);
    endtask
    task t_send;
        apb(1, `TPQ_OFF_PKT_NUM, pn[0]); apb(1, `TPQ_OFF_POINTER, 0);
        apb(1, `TPQ_OFF_DATA, 32'h1234_5678);
        chk({ram_pkt, ram_ptr}, {pn[0], 11'h000});
        chk(ram_wdata, 32'h1234_5678);
        apb(0, `TPQ_OFF_POINTER, 0); chk(r[10:0], 11'h004);
        apb(1, `TPQ_OFF_MMU_CMD, 3); wt(0, 1);
        apb(1, `TPQ_OFF_CTRL, 1); wt(0, 0); chk(pk, pn[0]);
        wt(1, 0); apb(0, `TPQ_OFF_INT_STAT, 0); chk(r[2:0], 3'h5);
        apb(0, `TPQ_OFF_ALLOC_RES, 0); chk(r[31], 0);
        apb(1, `TPQ_OFF_INT_STAT, 7);
    endtask
    task t_fail;
        fail_req <= 1;
        apb(1, `TPQ_OFF_CTRL, 3); apb(1, `TPQ_OFF_PKT_NUM, pn[1]);
        apb(1, `TPQ_OFF_MMU_CMD, 3); wt(0, 1);
        defer_ok <= 1; wt(0, 0); chk(pk, pn[1]);
        wt(1, 0); apb(0, `TPQ_OFF_INT_STAT, 0); chk({irq, r[1]}, 2'b11);
        apb(0, `TPQ_OFF_CTRL, 0); chk(r[0], 0);
        apb(0, `TPQ_OFF_FIFO_PORT, 0); chk({r[15], r[3:0]}, {1'b0, pn[1]});
        apb(0, `TPQ_OFF_TX_STATUS, 0); chk(r[15:0], 16'h0001);
        fail_req <= 0;
        apb(1, `TPQ_OFF_INT_STAT, 7); apb(1, `TPQ_OFF_PKT_NUM, pn[1]);
        apb(1, `TPQ_OFF_CTRL, 1); apb(1, `TPQ_OFF_MMU_CMD, 3);
        wt(0, 0); chk(pk, pn[1]);
        wt(1, 0); apb(0, `TPQ_OFF_INT_STAT, 0); chk(r[2:1], 2'b10);
    endtask
    task t_rel;
        apb(1, `TPQ_OFF_MMU_CMD, 32'h07ff_0001);
        apb(1, `TPQ_OFF_MMU_CMD, 32'h07ff_0001);
        apb(0, `TPQ_OFF_ALLOC_RES, 0); chk(r[31], 1);
        apb(1, `TPQ_OFF_PKT_NUM, pn[2]); apb(1, `TPQ_OFF_MMU_CMD, 2);
        apb(0, `TPQ_OFF_ALLOC_RES, 0); chk(r[31], 0);
    endtask
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_alloc;
        t_send;
        t_fail;
        t_rel;
        results;
    end
endmodule // tb_tpq_queue
`default_nettype wire
